/* File: hdl/prog_pkg.sv */
// Shared constants and types for the setpoint program run/hold control.
package prog_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ          = 25_000_000;
    localparam int HALF_SEC_MS     = 500;
    localparam int HALF_SEC_CYCLES = CLK_HZ / 1000 * HALF_SEC_MS;
    localparam int DEBOUNCE_MS     = 20;
    localparam int DEBOUNCE_CYCLES = CLK_HZ / 1000 * DEBOUNCE_MS;
    localparam int TICKS_PER_MIN   = 120;

    // ------------------------------------------------------------
    // Widths, ranges and reset values
    // ------------------------------------------------------------
    localparam int         TV_W         = 16;
    localparam int         SEG_COUNT    = 12;
    localparam logic [3:0] SEG_FIRST    = 4'h1;
    localparam logic [3:0] SEG_LAST     = 4'hC;
    localparam logic [6:0] MAX_CYCLES   = 7'h63;
    localparam logic [5:0] MIN_TOP      = 6'h3B;
    localparam logic [TV_W-1:0] TV_RESET = 16'h0000;
    localparam logic [TV_W-1:0] TV_STEP  = 16'h0001;
    localparam logic [TV_W-1:0] TV_MAX   = 16'hFFFF;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_READY = 4'b0001,
        ST_RUN   = 4'b0010,
        ST_HOLD  = 4'b0100,
        ST_OFF   = 4'b1000
    } prog_state_t;

    typedef enum logic [2:0] {
        DI_NONE  = 3'h0,
        DI_RUN   = 3'h1,
        DI_HOLD  = 3'h2,
        DI_RESTART_CYCLE_INPUT = 3'h3,
        DI_BEGIN = 3'h4
    } di_func_t;

    typedef struct packed {
        logic run;
        logic hold;
        logic up;
        logic down;
    } keys_t;

    typedef struct packed {
        logic [6:0] hours;
        logic [5:0] minutes;
    } seg_time_t;

    typedef struct packed {
        logic [3:0] seg;
        logic       soak;
        logic [6:0] hours;
        logic [5:0] minutes;
    } seg_readout_t;

    typedef struct packed {
        logic [3:0] start_seg;
        logic [3:0] end_seg;
        logic [6:0] recycles;
        logic       end_hold;
        logic       end_manual;
    } program_config_group_t;

endpackage : prog_pkg

/* File: hdl/contact_filter.sv */
// Synchroniser and debouncer for one dry-contact input.
`timescale 1ns/1ps
`default_nettype none
module contact_filter #(
    parameter int CYCLES = 500000
) (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic raw,
    output var  logic level_r,
    output var  logic rise_r,
    output var  logic fall_r
);

    logic        sync1_r;
    logic        sync2_r;
    logic [19:0] cnt_r;
    logic        differs;
    logic        settled;

    assign differs = sync2_r != level_r;
    assign settled = differs && (cnt_r == 20'(CYCLES - 1));

    // ------------------------------------------------------------
    // Filter
    // ------------------------------------------------------------
    // sync and debounce
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            cnt_r   <= '0;
            level_r <= 1'b0;
            rise_r  <= 1'b0;
            fall_r  <= 1'b0;
        end else begin
            sync1_r <= raw;
            sync2_r <= sync1_r;
            cnt_r   <= (differs && !settled) ? cnt_r + 20'h00001 : '0;
            level_r <= settled ? sync2_r : level_r;
            rise_r  <= settled && sync2_r;
            fall_r  <= settled && !sync2_r;
        end
    end

endmodule : contact_filter
`default_nettype wire

/* File: hdl/program_run_hold.sv */
// Run/hold sequencing of a ramp/soak setpoint program.
//
// Summary of operation
// - Up/down keys adjust the local setpoint before the program starts.
// - Run key starts the program and lights the running indicator.
// - Hold key freezes the program and shows the hold indicator.
// - Hold contact closure forces a running program into hold.
// - Hold indicator blinks while a hold contact that stopped a running program is closed.
// - Key presses win over the contact for run and hold.
// - Opening the hold contact resumes a program that the contact stopped.
// - Report segment 1 to 12, ramp or soak, and time left.
// - Keep and report remaining cycles, 0 to 99.
// - At the end, enter hold or disable programming per end state.
// - At the end, keep last setpoint or go manual with failsafe.
// - After power loss: hold at start, pre-program setpoint restored.
// - After power loss, control mode comes from the power-up setting.
// - Run contact closure places a running or held program in run.
// - Hold contact closure places a running or held program in hold.
// - Restart_cycle_input closure restarts the current cycle, mode unchanged.
// - Opening a run, hold or restart_cycle_input contact restores prior state.
// - Begin closure, while running or held, goes to first segment in hold; opening ignored.
// - Segment parameters change only when not running, refused while running.
`timescale 1ns/1ps
`default_nettype none
module program_run_hold #(
    parameter int HALF_SEC_P = prog_pkg::HALF_SEC_CYCLES,
    parameter int DEBOUNCE_P = prog_pkg::DEBOUNCE_CYCLES
) (
    input  wire logic                            clk,
    input  wire logic                            reset_n,
    input  wire prog_pkg::keys_t                 keys,
    input  wire logic                            contact_in,
    input  wire prog_pkg::di_func_t              di_func,
    input  wire prog_pkg::program_config_group_t cfg,
    input  wire logic                            param_wr,
    input  wire logic [3:0]                      param_seg,
    input  wire prog_pkg::seg_time_t             param_time,
    input  wire logic                            power_lost_in_prog,
    input  wire logic [15:0]                     saved_tv,
    input  wire logic                            power_up_mode_select,
    output var  logic [15:0]                     target_value_r,
    output var  logic [15:0]                     start_tv_r,
    output var  logic                            run_ind_r,
    output var  logic                            hold_ind_r,
    output var  logic                            program_active_r,
    output var  prog_pkg::seg_readout_t          readout_r,
    output var  logic [6:0]                      cycles_left_readout_r,
    output var  logic                            manual_mode_r,
    output var  logic                            failsafe_out_r,
    output var  logic                            param_refused_r
);
    import prog_pkg::*;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    prog_state_t  state_r, state_nxt;
    prog_state_t  prior_r, prior_nxt;
    seg_readout_t readout_nxt;
    seg_time_t    seg_mem [1:SEG_COUNT];
    logic [23:0]  div_r;
    logic [6:0]   tick_cnt_r;
    logic         half_tick;
    logic         min_tick;
    logic         blink_r;
    logic         pu_done_r;
    logic         di_latched_r, di_latched_nxt;
    logic         ext_hold_r, ext_hold_nxt;
    logic [6:0]   cycles_nxt;
    logic [15:0]  target_nxt;
    logic [15:0]  start_tv_nxt;
    logic         manual_nxt;
    logic         failsafe_nxt;
    logic         active_nxt;

    // ------------------------------------------------------------
    // Contact filter
    // ------------------------------------------------------------
    logic di_level;
    logic di_rise;
    logic di_fall;

    contact_filter #(
        .CYCLES (DEBOUNCE_P)
    ) u_filter (
        .clk     (clk),
        .reset_n (reset_n),
        .raw     (contact_in),
        .level_r (di_level),
        .rise_r  (di_rise),
        .fall_r  (di_fall)
    );

    // ------------------------------------------------------------
    // Time base
    // ------------------------------------------------------------
    // A single divider feeds both the blink and the minute count, so the
    // segment clock is only as fine as half a second.
    assign half_tick = div_r == 24'(HALF_SEC_P - 1);
    assign min_tick  = half_tick && (tick_cnt_r == 7'(TICKS_PER_MIN - 1));

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            div_r      <= '0;
            tick_cnt_r <= '0;
            blink_r    <= 1'b0;
        end else begin
            div_r      <= half_tick ? '0 : div_r + 24'h000001;
            tick_cnt_r <= min_tick ? '0
                        : tick_cnt_r + {6'h00, half_tick};
            blink_r    <= blink_r ^ half_tick;
        end
    end

    // ------------------------------------------------------------
    // Decodes
    // ------------------------------------------------------------
    wire is_run     = state_r == ST_RUN;
    wire is_hold    = state_r == ST_HOLD;
    wire is_idle    = (state_r == ST_READY) || (state_r == ST_OFF);
    wire key_rh     = keys.run || keys.hold;
    wire di_close   = di_rise && (di_func != DI_NONE);
    wire di_open    = di_fall && di_latched_r;
    wire time_zero  = (readout_r.hours == 7'h00)
                   && (readout_r.minutes == 6'h00);
    wire at_end_seg = readout_r.seg == cfg.end_seg;
    wire seg_done   = is_run && min_tick && time_zero;
    wire [3:0] next_seg = readout_r.seg + 4'h1;
    wire seg_time_t start_time = seg_mem[cfg.start_seg];
    wire seg_time_t next_time  = seg_mem[next_seg];
    wire tv_up_ok   = target_value_r <= (TV_MAX - TV_STEP);
    wire tv_dn_ok   = target_value_r >= TV_STEP;
    wire param_ok   = param_wr && !is_run && (param_seg >= SEG_FIRST)
                   && (param_seg <= SEG_LAST);

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_nxt      = state_r;
        prior_nxt      = prior_r;
        readout_nxt    = readout_r;
        di_latched_nxt = di_latched_r;
        ext_hold_nxt   = ext_hold_r;
        cycles_nxt     = cycles_left_readout_r;
        target_nxt     = target_value_r;
        start_tv_nxt   = start_tv_r;
        manual_nxt     = manual_mode_r;
        failsafe_nxt   = failsafe_out_r;
        active_nxt     = program_active_r;

        if (!pu_done_r) begin
            if (power_lost_in_prog) begin
                state_nxt           = ST_HOLD;
                readout_nxt.seg     = cfg.start_seg;
                readout_nxt.soak    = ~cfg.start_seg[0];
                readout_nxt.hours   = start_time.hours;
                readout_nxt.minutes = start_time.minutes;
                cycles_nxt          = (cfg.recycles > MAX_CYCLES)
                                    ? MAX_CYCLES : cfg.recycles;
                target_nxt          = saved_tv;
                start_tv_nxt        = saved_tv;
                active_nxt          = 1'b1;
                manual_nxt          = power_up_mode_select;
            end
        end else if (key_rh) begin
            di_latched_nxt = 1'b0;
            ext_hold_nxt   = 1'b0;
            if (keys.run && is_idle) begin
                state_nxt           = ST_RUN;
                readout_nxt.seg     = cfg.start_seg;
                readout_nxt.soak    = ~cfg.start_seg[0];
                readout_nxt.hours   = start_time.hours;
                readout_nxt.minutes = start_time.minutes;
                cycles_nxt          = (cfg.recycles > MAX_CYCLES)
                                    ? MAX_CYCLES : cfg.recycles;
                start_tv_nxt        = target_value_r;
                manual_nxt          = 1'b0;
                failsafe_nxt        = 1'b0;
                active_nxt          = 1'b1;
            end else if (keys.run && is_hold) begin
                state_nxt = ST_RUN;
            end else if (keys.hold && is_run) begin
                state_nxt = ST_HOLD;
            end
        end else if (di_close && !is_idle) begin
            prior_nxt      = state_r;
            di_latched_nxt = di_func != DI_BEGIN;
            case (di_func)
                DI_RUN: begin
                    state_nxt = ST_RUN;
                end
                DI_HOLD: begin
                    state_nxt    = ST_HOLD;
                    ext_hold_nxt = is_run;
                end
                DI_RESTART_CYCLE_INPUT, DI_BEGIN: begin
                    readout_nxt.seg     = cfg.start_seg;
                    readout_nxt.soak    = ~cfg.start_seg[0];
                    readout_nxt.hours   = start_time.hours;
                    readout_nxt.minutes = start_time.minutes;
                    if (di_func == DI_BEGIN) begin
                        state_nxt = ST_HOLD;
                    end
                end
                default: begin
                    di_latched_nxt = 1'b0;
                end
            endcase
        end else if (di_open) begin
            state_nxt      = prior_r;
            di_latched_nxt = 1'b0;
            ext_hold_nxt   = 1'b0;
        end else if (seg_done) begin
            if (!at_end_seg) begin
                readout_nxt.seg     = next_seg;
                readout_nxt.soak    = ~next_seg[0];
                readout_nxt.hours   = next_time.hours;
                readout_nxt.minutes = next_time.minutes;
            end else if (cycles_left_readout_r != 7'h00) begin
                cycles_nxt          = cycles_left_readout_r - 7'h01;
                readout_nxt.seg     = cfg.start_seg;
                readout_nxt.soak    = ~cfg.start_seg[0];
                readout_nxt.hours   = start_time.hours;
                readout_nxt.minutes = start_time.minutes;
            end else begin
                state_nxt      = cfg.end_hold ? ST_HOLD : ST_OFF;
                active_nxt     = 1'b0;
                di_latched_nxt = 1'b0;
                manual_nxt     = cfg.end_manual;
                failsafe_nxt   = cfg.end_manual;
            end
        end else if (is_run && min_tick) begin
            if (readout_r.minutes == 6'h00) begin
                readout_nxt.hours   = readout_r.hours - 7'h01;
                readout_nxt.minutes = MIN_TOP;
            end else begin
                readout_nxt.minutes = readout_r.minutes - 6'h01;
            end
        end

        if (pu_done_r && is_idle && state_nxt != ST_RUN) begin
            if (keys.up && !keys.down && tv_up_ok) begin
                target_nxt = target_value_r + TV_STEP;
            end else if (keys.down && !keys.up && tv_dn_ok) begin
                target_nxt = target_value_r - TV_STEP;
            end
        end

        // External hold only lasts while the program sits in hold.
        if (state_nxt != ST_HOLD) begin
            ext_hold_nxt = 1'b0;
        end
    end

    wire hold_ind_nxt = (state_nxt == ST_HOLD)
                     && (!ext_hold_nxt || blink_r);
    wire run_ind_nxt  = state_nxt == ST_RUN;

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r               <= ST_READY;
            prior_r               <= ST_READY;
            readout_r             <= '{seg: SEG_FIRST, soak: 1'b0,
                                       hours: 7'h00, minutes: 6'h00};
            pu_done_r             <= 1'b0;
            di_latched_r          <= 1'b0;
            ext_hold_r            <= 1'b0;
            cycles_left_readout_r <= 7'h00;
            target_value_r        <= TV_RESET;
            start_tv_r            <= TV_RESET;
            manual_mode_r         <= 1'b0;
            failsafe_out_r        <= 1'b0;
            program_active_r      <= 1'b0;
            run_ind_r             <= 1'b0;
            hold_ind_r            <= 1'b0;
        end else begin
            state_r               <= state_nxt;
            prior_r               <= prior_nxt;
            readout_r             <= readout_nxt;
            pu_done_r             <= 1'b1;
            di_latched_r          <= di_latched_nxt;
            ext_hold_r            <= ext_hold_nxt;
            cycles_left_readout_r <= cycles_nxt;
            target_value_r        <= target_nxt;
            start_tv_r            <= start_tv_nxt;
            manual_mode_r         <= manual_nxt;
            failsafe_out_r        <= failsafe_nxt;
            program_active_r      <= active_nxt;
            run_ind_r             <= run_ind_nxt;
            hold_ind_r            <= hold_ind_nxt;
        end
    end

    // ------------------------------------------------------------
    // Segment parameter store
    // ------------------------------------------------------------
    // writes refused while running
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            param_refused_r <= 1'b0;
        end else begin
            param_refused_r <= param_wr && is_run;
        end
    end

    // The store has no reset; segments read as unknown until written.
    always_ff @(posedge clk) begin
        if (param_ok) begin
            seg_mem[param_seg] <= param_time;
        end
    end

    // The contact level itself only matters through its edges.
    wire unused_level = di_level;

endmodule : program_run_hold
`default_nettype wire

/* File: dv/prog_run_hold_monitor.sv */
// Checker for the run/hold sequencing ports of the program block.
`timescale 1ns/1ps
`default_nettype none
module prog_run_hold_monitor (
    input wire logic                   clk,
    input wire logic                   reset_n,
    input wire prog_pkg::keys_t        keys,
    input wire logic                   param_wr,
    input wire logic [15:0]            target_value_r,
    input wire logic                   run_ind_r,
    input wire logic                   hold_ind_r,
    input wire prog_pkg::seg_readout_t readout_r,
    input wire logic [6:0]             cycles_left_readout_r,
    input wire logic                   manual_mode_r,
    input wire logic                   failsafe_out_r,
    input wire logic                   param_refused_r
);
    import prog_pkg::*;
    // ----------------------------------------------------------
    // Properties
    // ----------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_run_key;
        keys.run |=> run_ind_r && !hold_ind_r;
    endproperty
    a_run_key: assert property (p_run_key)
        else $error("run key did not start the program");
    property p_hold_key;
        keys.hold && !keys.run && run_ind_r |=> !run_ind_r && hold_ind_r;
    endproperty
    a_hold_key: assert property (p_hold_key)
        else $error("hold key did not hold the program");
    property p_up_step;
        keys.up && !keys.down && !run_ind_r && !hold_ind_r &&
        target_value_r != 16'hFFFF
        |=> target_value_r == $past(target_value_r) + 16'h0001;
    endproperty
    a_up_step: assert property (p_up_step)
        else $error("up key did not step the setpoint");
    property p_keys_locked;
        (keys.up || keys.down) && run_ind_r |=> $stable(target_value_r);
    endproperty
    a_keys_locked: assert property (p_keys_locked)
        else $error("setpoint moved while running");
    property p_param_refuse;
        param_wr |=> param_refused_r == $past(run_ind_r);
    endproperty
    a_param_refuse: assert property (p_param_refuse)
        else $error("parameter refusal wrong");
    property p_seg_range;
        readout_r.seg >= 4'h1 && readout_r.seg <= 4'hC &&
        readout_r.soak == !readout_r.seg[0];
    endproperty
    a_seg_range: assert property (p_seg_range)
        else $error("segment number or kind out of range");
    property p_cycles_range;
        cycles_left_readout_r <= 7'h63;
    endproperty
    a_cycles_range: assert property (p_cycles_range)
        else $error("cycle count above limit");
    property p_end_manual;
        $fell(run_ind_r) && !hold_ind_r && cycles_left_readout_r == 7'h00
        |-> manual_mode_r == failsafe_out_r;
    endproperty
    a_end_manual: assert property (p_end_manual)
        else $error("end action mode and failsafe disagree");
endmodule : prog_run_hold_monitor

bind program_run_hold prog_run_hold_monitor prog_run_hold_monitor_i (
    .clk(clk), .reset_n(reset_n), .keys(keys), .param_wr(param_wr),
    .target_value_r(target_value_r), .run_ind_r(run_ind_r),
    .hold_ind_r(hold_ind_r), .readout_r(readout_r),
    .cycles_left_readout_r(cycles_left_readout_r),
    .manual_mode_r(manual_mode_r), .failsafe_out_r(failsafe_out_r),
    .param_refused_r(param_refused_r)
);
`default_nettype wire

/* File: dv/contact_switch_model.sv */
// Behavioural dry contact that bounces on every change of position.
`timescale 1ns/1ps
`default_nettype none
module contact_switch_model (
    input  wire logic closed_req,
    output var  logic contact_in
);
    // An open contact reads low; the bounce is far shorter than the filter.
    initial contact_in = 1'b0;
    always @(closed_req) begin
        repeat (3) begin
            #7 contact_in = ~closed_req;
            #5 contact_in = closed_req;
        end
    end
endmodule : contact_switch_model
`default_nettype wire

/* File: dv/testbench.sv */
// Self-checking bench for the program run/hold sequencing block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
    failures++; $display("BAD %s exp=%0h got=%0h", n, e, g); end end
`define WAIT_UNTIL(c, n) for (int w = 0; w < (n) && !(c); w++) \
    @(negedge clk);
module testbench;
    import prog_pkg::*;
    // Short ticks keep a minute at 480 cycles and the filter at 4.
    localparam int HS = 4;
    localparam int DB = 4;
    logic                  clk = 1'b0;
    logic                  reset_n;
    keys_t                 keys;
    logic                  closed_req;
    logic                  contact_in;
    di_func_t              di_func;
    program_config_group_t cfg;
    logic                  param_wr;
    logic [3:0]            param_seg;
    seg_time_t             param_time;
    logic                  power_lost_in_prog;
    logic [15:0]           saved_tv;
    logic                  power_up_mode_select;
    logic [15:0]           target_value_r;
    logic [15:0]           start_tv_r;
    logic                  run_ind_r;
    logic                  hold_ind_r;
    logic                  program_active_r;
    seg_readout_t          readout_r;
    logic [6:0]            cycles_left_readout_r;
    logic                  manual_mode_r;
    logic                  failsafe_out_r;
    logic                  param_refused_r;
    int                    failures = 0;
    int                    total_checks = 0;
    int                    n;
    logic                  prev;
    always #20 clk = ~clk;
    program_run_hold #(.HALF_SEC_P(HS), .DEBOUNCE_P(DB)) program_run_hold_i (
        .clk(clk), .reset_n(reset_n), .keys(keys), .contact_in(contact_in),
        .di_func(di_func), .cfg(cfg), .param_wr(param_wr),
        .param_seg(param_seg), .param_time(param_time),
        .power_lost_in_prog(power_lost_in_prog), .saved_tv(saved_tv),
        .power_up_mode_select(power_up_mode_select),
        .target_value_r(target_value_r), .start_tv_r(start_tv_r),
        .run_ind_r(run_ind_r), .hold_ind_r(hold_ind_r),
        .program_active_r(program_active_r), .readout_r(readout_r),
        .cycles_left_readout_r(cycles_left_readout_r),
        .manual_mode_r(manual_mode_r), .failsafe_out_r(failsafe_out_r),
        .param_refused_r(param_refused_r));
    contact_switch_model contact_switch_model_i (
        .closed_req(closed_req), .contact_in(contact_in));
    // ----------------------------------------------------------
    // Access tasks
    // ----------------------------------------------------------
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask : cyc
    task automatic press(input keys_t k);
        @(negedge clk);
        keys = k;
        @(negedge clk);
        keys = '0;
    endtask : press
    task automatic wr_seg(input logic [3:0] s, input seg_time_t t);
        @(negedge clk);
        param_wr = 1'b1;
        param_seg = s;
        param_time = t;
        @(negedge clk);
        param_wr = 1'b0;
    endtask : wr_seg
    task automatic contact(input di_func_t f, input logic c);
        di_func = f;
        closed_req = c;
        cyc(DB + 16);
    endtask : contact
    task automatic do_reset();
        reset_n = 1'b0;
        cyc(16);
        reset_n = 1'b1;
        cyc(2);
    endtask : do_reset
    task automatic final_report();
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report
    initial begin
        cyc(40000);
        failures++;
        final_report();
    end
    initial begin
        reset_n = 1'b0;
        keys = '0;
        closed_req = 1'b0;
        di_func = DI_NONE;
        cfg = '{4'h1, 4'h2, 7'h01, 1'b0, 1'b1};
        param_wr = 1'b0;
        param_seg = 4'h1;
        param_time = '0;
        power_lost_in_prog = 1'b0;
        saved_tv = 16'h1234;
        power_up_mode_select = 1'b1;
        do_reset();
        wr_seg(4'h1, 13'h0001);
        wr_seg(4'h2, 13'h0001);
        `CHK("accept", 1'b0, param_refused_r)
        repeat (3) press(4'h2);
        press(4'h1);
        `CHK("tv_step", 16'h0002, target_value_r)
        repeat (3) press(4'h1);
        press(4'h3);
        `CHK("tv_floor", 16'h0000, target_value_r)
        repeat (5) press(4'h2);
        press(4'h8);
        `CHK("run", 1'b1, run_ind_r)
        `CHK("start_tv", 16'h0005, start_tv_r)
        `CHK("readout", 18'h04001, readout_r)
        `CHK("cycles", 7'h01, cycles_left_readout_r)
        press(4'h2);
        wr_seg(4'h1, 13'h0002);
        `CHK("refused", 1'b1, param_refused_r)
        `CHK("tv_locked", 16'h0005, target_value_r)
        press(4'h4);
        `CHK("hold", 2'b01, {run_ind_r, hold_ind_r})
        press(4'h4);
        press(4'h8);
        contact(DI_HOLD, 1'b1);
        `CHK("ext_hold", 1'b0, run_ind_r)
        n = 0;
        prev = hold_ind_r;
        repeat (8 * HS) begin
            @(negedge clk);
            if (hold_ind_r !== prev) n++;
            prev = hold_ind_r;
        end
        `CHK("blink", 8, n)
        contact(DI_HOLD, 1'b0);
        `CHK("resume", 1'b1, run_ind_r)
        contact(DI_HOLD, 1'b1);
        press(4'h8);
        `CHK("key_wins", 1'b1, run_ind_r)
        contact(DI_HOLD, 1'b0);
        press(4'h4);
        contact(DI_RUN, 1'b1);
        `CHK("di_run", 1'b1, run_ind_r)
        contact(DI_RUN, 1'b0);
        `CHK("revert", 2'b01, {run_ind_r, hold_ind_r})
        press(4'h8);
        `WAIT_UNTIL(readout_r.seg == 4'h2, 1500)
        `CHK("soak_seg", 18'h0A001, readout_r)
        contact(DI_RESTART_CYCLE_INPUT, 1'b1);
        `CHK("restart_cycle_input", 5'h03, {readout_r.seg, run_ind_r})
        contact(DI_RESTART_CYCLE_INPUT, 1'b0);
        `CHK("restart_cycle_input_open", 1'b1, run_ind_r)
        contact(DI_BEGIN, 1'b1);
        `CHK("begin", 6'h05, {readout_r.seg, run_ind_r, hold_ind_r})
        `CHK("begin_cyc", 7'h01, cycles_left_readout_r)
        contact(DI_BEGIN, 1'b0);
        `CHK("begin_open", 2'b01, {run_ind_r, hold_ind_r})
        press(4'h8);
        `WAIT_UNTIL(run_ind_r == 1'b0, 6000)
        `CHK("end_off", 2'b00, {run_ind_r, hold_ind_r})
        `CHK("end_act", 1'b0, program_active_r)
        `CHK("end_cyc", 7'h00, cycles_left_readout_r)
        `CHK("end_man", 2'b11, {manual_mode_r, failsafe_out_r})
        cfg.end_hold = 1'b1;
        cfg.end_manual = 1'b0;
        power_lost_in_prog = 1'b1;
        do_reset();
        `CHK("pwr_hold", 2'b01, {run_ind_r, hold_ind_r})
        `CHK("pwr_tv", 16'h1234, target_value_r)
        `CHK("pwr_act", 1'b1, program_active_r)
        `CHK("pwr_seg", 18'h04001, readout_r)
        `CHK("pwr_mode", 1'b1, manual_mode_r)
        power_lost_in_prog = 1'b0;
        press(4'h8);
        `WAIT_UNTIL(run_ind_r == 1'b0, 6000)
        `CHK("end_hold", 2'b01, {run_ind_r, hold_ind_r})
        `CHK("end_auto", 1'b0, manual_mode_r)
        final_report();
    end
endmodule : testbench
`default_nettype wire
